/* pkg/fpsc_if.sv */
`timescale 1ns/1ps
interface fpsc_if;
    logic        bus_we;
    logic        bus_re;
    logic [15:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic        bus_rvalid;
    logic        write_protect_n;

    modport dev  (input bus_we, bus_re, bus_addr, bus_wdata, write_protect_n,
                  output bus_rdata, bus_rvalid);
    modport host (output bus_we, bus_re, bus_addr, bus_wdata, write_protect_n,
                  input bus_rdata, bus_rvalid);
endinterface

/* pkg/fpsc_map.svh */
`ifndef FPSC_MAP_SVH
`define FPSC_MAP_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define FPSC_CMD_PROG      8'h40
`define FPSC_CMD_PROG_ALT  8'h10
`define FPSC_CMD_ERASE     8'h20
`define FPSC_CMD_CONFIRM   8'hD0
`define FPSC_CMD_SUSPEND   8'hB0
`define FPSC_CMD_STATUS    8'h70
`define FPSC_CMD_CLEAR     8'h50
`define FPSC_CMD_ARRAY     8'hFF

// ----------------------------------------
// op_status_reg field positions
// ----------------------------------------
`define FPSC_SR_READY      7
`define FPSC_SR_EPAUSE     6
`define FPSC_SR_EFAIL      5
`define FPSC_SR_PFAIL      4
`define FPSC_SR_SUPPLY     3
`define FPSC_SR_PPAUSE     2
`define FPSC_SR_LOCK       1
`define FPSC_SR_RST        8'h80
`define FPSC_SR_ERR_MASK   8'h3A

// ----------------------------------------
// array geometry
// ----------------------------------------
`define FPSC_WORDS         64
`define FPSC_BLK_WORDS     8
`define FPSC_ERASED        16'hFFFF

// ----------------------------------------
// timing
// ----------------------------------------
`define FPSC_CLK_NS        10
`define FPSC_PROG_NS       2000
`define FPSC_ERASE_NS      8000
`define FPSC_SUSP_NS       200
`define FPSC_PROG_CYC      ((`FPSC_PROG_NS + `FPSC_CLK_NS - 1) / `FPSC_CLK_NS)
`define FPSC_ERASE_CYC     ((`FPSC_ERASE_NS + `FPSC_CLK_NS - 1) / `FPSC_CLK_NS)
`define FPSC_SUSP_CYC      (`FPSC_SUSP_NS / `FPSC_CLK_NS)

`endif

/* pkg/fpsc_pkg.sv */
package fpsc_pkg;
    typedef enum logic [2:0] {
        ST_READY, ST_PROG, ST_PROG_HELD, ST_ERASE, ST_ERASE_HELD, ST_NEST_PROG, ST_NEST_HELD
    } fpsc_state_e;

    typedef enum logic [2:0] {
        OP_PROGRAM, OP_ERASE, OP_SUSPEND, OP_RESUME, OP_READ_ARRAY, OP_READ_STATUS, OP_CLEAR,
        OP_READ
    } fpsc_op_e;

    typedef enum logic [2:0] {
        H_IDLE, H_SECOND, H_POLL, H_POLL_WAIT, H_READ_WAIT, H_CLEAR, H_DONE
    } fpsc_host_e;
endpackage

/* rtl/fpsc_device.sv */
// How it works
// - supply low aborts, sets status bit 3
// - supply sampled at the confirm/data write and while operations run
// - program suspend sets bits 7,2 until resume
// - locked block with protect low aborts, bit 1
// - program is setup code then address/data
// - after program pair, reads return status
// - host polls ready bit for completion
// - host checks bit 7, then 5,4,3,1
// - host clears status after an error
// - status read mode holds until a read array command or an accepted clear command
// - erase suspend pauses after bounded latency
// - reads return status after erase suspend
// - paused erase shows bits 7 and 6
// - read array allowed while erase paused
// - program other block while erase paused
// - nested program is itself suspendable
// - paused erase accepts status and resume too
// - host copies wp_level to write protect every cycle, paused or not
// - erase resume clears bits 6 and 7
// - reads return status after erase resume
// - erase restarts only after nested program ends
// - error bits sticky until clear command in ST_READY or ST_PROG_HELD
// - bit 7 low while operation runs
`timescale 1ns/1ps
`include "fpsc_map.svh"
module fpsc_device import fpsc_pkg::*; (
    input  wire logic       clock,
    input  wire logic       rst_n,
    fpsc_if.dev             bus,
    input  wire logic       supply_low,
    input  wire logic [7:0] block_locked,
    output logic            op_busy,
    output logic            erase_held
);
    fpsc_state_e  state;
    logic [15:0]  prog_cnt;
    logic [15:0]  erase_cnt;
    logic [15:0]  lat_cnt;
    logic         susp_pend;
    logic         prog_setup;
    logic         erase_setup;
    logic [5:0]   prog_addr;
    logic [15:0]  prog_data;
    logic [2:0]   erase_blk;
    logic         status_mode;
    logic         fail_erase;
    logic         fail_prog;
    logic         supply_flag;
    logic         locked_flag;
    logic [15:0]  mem [`FPSC_WORDS];

    logic [7:0]   cmd;
    logic [2:0]   blk;
    logic         prog_run;
    logic         erase_run;
    logic         ready;
    logic         paused_erase;
    logic         paused_prog;
    logic [7:0]   status;
    logic         go_prog;
    logic         go_erase;
    logic         do_psetup;
    logic         do_esetup;
    logic         do_susp;
    logic         do_resume;
    logic         do_clr;
    logic         to_status;
    logic         to_array;
    logic         abort;
    logic         set_e;
    logic         set_p;
    logic         set_v;
    logic         set_l;
    logic         prog_done;
    logic         erase_done;
    logic         lat_done;

    assign cmd          = bus.bus_wdata[7:0];
    assign blk          = bus.bus_addr[5:3];
    assign prog_run     = (state == ST_PROG) || (state == ST_NEST_PROG);
    assign erase_run    = (state == ST_ERASE);
    assign ready        = !prog_run && !erase_run;
    assign paused_erase = (state == ST_ERASE_HELD) || (state == ST_NEST_PROG)
                          || (state == ST_NEST_HELD);
    assign paused_prog  = (state == ST_PROG_HELD) || (state == ST_NEST_HELD);
    assign status       = {ready, paused_erase, fail_erase, fail_prog,
                           supply_flag, paused_prog, locked_flag, 1'b0};
    assign prog_done    = prog_run && (prog_cnt == 16'h0001) && !abort;
    assign erase_done   = erase_run && (erase_cnt == 16'h0001) && !abort;
    assign lat_done     = susp_pend && (lat_cnt == 16'h0001);

    // ----------------------------------------
    // command decoder
    // ----------------------------------------
    always_comb begin
        go_prog   = 1'b0;
        go_erase  = 1'b0;
        do_psetup = 1'b0;
        do_esetup = 1'b0;
        do_susp   = 1'b0;
        do_resume = 1'b0;
        do_clr    = 1'b0;
        to_status = 1'b0;
        to_array  = 1'b0;
        set_e     = 1'b0;
        set_p     = 1'b0;
        set_v     = 1'b0;
        set_l     = 1'b0;
        abort     = 1'b0;
        if ((prog_run || erase_run) && supply_low) begin
            abort = 1'b1;
            set_v = 1'b1;
            set_p = prog_run;
            set_e = erase_run;
        end
        if (bus.bus_we) begin
            if (prog_setup) begin
                to_status = 1'b1;
                if (paused_erase && (blk == erase_blk)) begin
                    set_p = 1'b1;
                end else if (supply_low) begin
                    set_v = 1'b1;
                    set_p = 1'b1;
                end else if (block_locked[blk] && !bus.write_protect_n) begin
                    set_l = 1'b1;
                    set_p = 1'b1;
                end else begin
                    go_prog = 1'b1;
                end
            end else if (erase_setup) begin
                to_status = 1'b1;
                if (cmd != `FPSC_CMD_CONFIRM) begin
                    set_e = 1'b1;
                    set_p = 1'b1;
                end else if (supply_low) begin
                    set_v = 1'b1;
                    set_e = 1'b1;
                end else if (block_locked[blk] && !bus.write_protect_n) begin
                    set_l = 1'b1;
                    set_e = 1'b1;
                end else begin
                    go_erase = 1'b1;
                end
            end else if (prog_run || erase_run) begin
                if ((cmd == `FPSC_CMD_SUSPEND) && !susp_pend) begin
                    do_susp = 1'b1;
                end
            end else begin
                unique case (cmd)
                    `FPSC_CMD_PROG, `FPSC_CMD_PROG_ALT: begin
                        do_psetup = (state == ST_READY) || (state == ST_ERASE_HELD);
                    end
                    `FPSC_CMD_ERASE: begin
                        do_esetup = (state == ST_READY);
                    end
                    `FPSC_CMD_CONFIRM: begin
                        do_resume = paused_erase || paused_prog;
                        to_status = do_resume;
                    end
                    `FPSC_CMD_CLEAR: begin
                        do_clr   = (state == ST_READY) || (state == ST_PROG_HELD);
                        to_array = do_clr;
                    end
                    `FPSC_CMD_STATUS: begin
                        to_status = 1'b1;
                    end
                    `FPSC_CMD_ARRAY: begin
                        to_array = 1'b1;
                    end
                    default: begin
                        to_status = 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // write state machine
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ST_READY;
            prog_cnt    <= 16'h0000;
            erase_cnt   <= 16'h0000;
            lat_cnt     <= 16'h0000;
            susp_pend   <= 1'b0;
            prog_setup  <= 1'b0;
            erase_setup <= 1'b0;
            prog_addr   <= 6'h00;
            prog_data   <= 16'h0000;
            erase_blk   <= 3'h0;
        end else begin
            if (bus.bus_we) begin
                prog_setup  <= do_psetup;
                erase_setup <= do_esetup;
            end
            if (go_prog) begin
                prog_addr <= bus.bus_addr[5:0];
                prog_data <= bus.bus_wdata;
                prog_cnt  <= 16'(`FPSC_PROG_CYC);
            end else if (prog_run) begin
                prog_cnt <= prog_cnt - 16'h0001;
            end
            if (go_erase) begin
                erase_blk <= blk;
                erase_cnt <= 16'(`FPSC_ERASE_CYC);
            end else if (erase_run) begin
                erase_cnt <= erase_cnt - 16'h0001;
            end
            if (do_susp) begin
                susp_pend <= 1'b1;
                lat_cnt   <= 16'(`FPSC_SUSP_CYC);
            end else if (lat_done || abort || prog_done || erase_done) begin
                susp_pend <= 1'b0;
            end else if (susp_pend) begin
                lat_cnt <= lat_cnt - 16'h0001;
            end
            unique case (state)
                ST_READY: begin
                    if (go_prog) begin
                        state <= ST_PROG;
                    end else if (go_erase) begin
                        state <= ST_ERASE;
                    end
                end
                ST_PROG: begin
                    if (abort || prog_done) begin
                        state <= ST_READY;
                    end else if (lat_done) begin
                        state <= ST_PROG_HELD;
                    end
                end
                ST_PROG_HELD: begin
                    if (do_resume) begin
                        state <= ST_PROG;
                    end
                end
                ST_ERASE: begin
                    if (abort || erase_done) begin
                        state <= ST_READY;
                    end else if (lat_done) begin
                        state <= ST_ERASE_HELD;
                    end
                end
                ST_ERASE_HELD: begin
                    if (go_prog) begin
                        state <= ST_NEST_PROG;
                    end else if (do_resume) begin
                        state <= ST_ERASE;
                    end
                end
                ST_NEST_PROG: begin
                    if (abort || prog_done) begin
                        state <= ST_ERASE_HELD;
                    end else if (lat_done) begin
                        state <= ST_NEST_HELD;
                    end
                end
                ST_NEST_HELD: begin
                    if (do_resume) begin
                        state <= ST_NEST_PROG;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // sticky error flags
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fail_erase  <= 1'b0;
            fail_prog   <= 1'b0;
            supply_flag <= 1'b0;
            locked_flag <= 1'b0;
        end else begin
            fail_erase  <= set_e | (fail_erase & ~do_clr);
            fail_prog   <= set_p | (fail_prog & ~do_clr);
            supply_flag <= set_v | (supply_flag & ~do_clr);
            locked_flag <= set_l | (locked_flag & ~do_clr);
        end
    end

    // ----------------------------------------
    // read mode
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_mode <= 1'b0;
        end else if (to_status || do_susp || do_psetup || do_esetup) begin
            status_mode <= 1'b1;
        end else if (to_array) begin
            status_mode <= 1'b0;
        end
    end

    // ----------------------------------------
    // array
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `FPSC_WORDS; i++) begin
                mem[i] <= `FPSC_ERASED;
            end
        end else if (prog_done) begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end else if (erase_done) begin
            for (int i = 0; i < `FPSC_BLK_WORDS; i++) begin
                mem[{erase_blk, 3'(i)}] <= `FPSC_ERASED;
            end
        end
    end

    // ----------------------------------------
    // read port and outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus.bus_rvalid <= 1'b0;
            bus.bus_rdata  <= 16'h0000;
            op_busy        <= 1'b0;
            erase_held     <= 1'b0;
        end else begin
            bus.bus_rvalid <= bus.bus_re;
            if (bus.bus_re) begin
                bus.bus_rdata <= status_mode ? {8'h00, status} : mem[bus.bus_addr[5:0]];
            end
            op_busy    <= !ready;
            erase_held <= paused_erase;
        end
    end
endmodule

/* rtl/fpsc_host.sv */
`timescale 1ns/1ps
`include "fpsc_map.svh"
module fpsc_host import fpsc_pkg::*; (
    input  wire logic        clock,
    input  wire logic        rst_n,
    fpsc_if.host             bus,
    input  wire logic        op_valid,
    input  wire fpsc_op_e    op_code,
    input  wire logic [15:0] op_addr,
    input  wire logic [15:0] op_data,
    input  wire logic        wp_level,
    output logic             op_ready,
    output logic             done,
    output logic             done_error,
    output logic [15:0]      done_data
);
    fpsc_host_e  hstate;
    fpsc_op_e    op;
    logic [15:0] addr;
    logic [15:0] data;
    logic [7:0]  first;

    always_comb begin
        unique case (op_code)
            OP_PROGRAM:     first = `FPSC_CMD_PROG;
            OP_ERASE:       first = `FPSC_CMD_ERASE;
            OP_SUSPEND:     first = `FPSC_CMD_SUSPEND;
            OP_RESUME:      first = `FPSC_CMD_CONFIRM;
            OP_READ_ARRAY:  first = `FPSC_CMD_ARRAY;
            OP_READ_STATUS: first = `FPSC_CMD_STATUS;
            OP_CLEAR:       first = `FPSC_CMD_CLEAR;
            OP_READ:        first = 8'h00;
        endcase
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hstate              <= H_IDLE;
            op                  <= OP_READ;
            addr                <= 16'h0000;
            data                <= 16'h0000;
            op_ready            <= 1'b1;
            done                <= 1'b0;
            done_error          <= 1'b0;
            done_data           <= 16'h0000;
            bus.bus_we          <= 1'b0;
            bus.bus_re          <= 1'b0;
            bus.bus_addr        <= 16'h0000;
            bus.bus_wdata       <= 16'h0000;
            bus.write_protect_n <= 1'b1;
        end else begin
            bus.write_protect_n <= wp_level;
            bus.bus_we          <= 1'b0;
            bus.bus_re          <= 1'b0;
            done                <= 1'b0;
            unique case (hstate)
                H_IDLE: begin
                    if (op_valid) begin
                        op           <= op_code;
                        addr         <= op_addr;
                        data         <= op_data;
                        op_ready     <= 1'b0;
                        bus.bus_addr <= op_addr;
                        if (op_code == OP_READ) begin
                            bus.bus_re <= 1'b1;
                            hstate     <= H_READ_WAIT;
                        end else begin
                            bus.bus_we    <= 1'b1;
                            bus.bus_wdata <= {8'h00, first};
                            hstate        <= H_SECOND;
                        end
                    end
                end
                H_SECOND: begin
                    if (op == OP_PROGRAM || op == OP_ERASE) begin
                        bus.bus_we    <= 1'b1;
                        bus.bus_wdata <= (op == OP_PROGRAM) ? data
                                         : {8'h00, `FPSC_CMD_CONFIRM};
                        hstate        <= H_POLL;
                    end else if (op == OP_SUSPEND || op == OP_RESUME) begin
                        hstate <= H_POLL;
                    end else if (op == OP_READ_STATUS) begin
                        bus.bus_re <= 1'b1;
                        hstate     <= H_READ_WAIT;
                    end else begin
                        hstate <= H_DONE;
                    end
                end
                H_POLL: begin
                    if (op_valid && (op_code == OP_SUSPEND) && (op != OP_SUSPEND)) begin
                        op            <= OP_SUSPEND;
                        bus.bus_we    <= 1'b1;
                        bus.bus_wdata <= {8'h00, `FPSC_CMD_SUSPEND};
                    end
                    bus.bus_re   <= 1'b1;
                    bus.bus_addr <= addr;
                    hstate       <= H_POLL_WAIT;
                end
                H_POLL_WAIT: begin
                    if (bus.bus_rvalid) begin
                        done_data <= bus.bus_rdata;
                        if (!bus.bus_rdata[`FPSC_SR_READY]) begin
                            hstate <= H_POLL;
                        end else if ((bus.bus_rdata[7:0] & `FPSC_SR_ERR_MASK) != 8'h00) begin
                            done_error <= 1'b1;
                            hstate     <= H_CLEAR;
                        end else begin
                            done_error <= 1'b0;
                            hstate     <= H_DONE;
                        end
                    end
                end
                H_CLEAR: begin
                    bus.bus_we    <= 1'b1;
                    bus.bus_wdata <= {8'h00, `FPSC_CMD_CLEAR};
                    hstate        <= H_DONE;
                end
                H_READ_WAIT: begin
                    if (bus.bus_rvalid) begin
                        done_data  <= bus.bus_rdata;
                        done_error <= 1'b0;
                        hstate     <= H_DONE;
                    end
                end
                H_DONE: begin
                    done     <= 1'b1;
                    op_ready <= 1'b1;
                    hstate   <= H_IDLE;
                end
            endcase
        end
    end
endmodule

/* testbench/fpsc_bus_assertions.sv */
`timescale 1ns/1ps
`include "fpsc_map.svh"
module fpsc_bus_assertions (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        bus_we,
    input wire logic        bus_re,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic        bus_rvalid
);
    // ----------------------------------------
    // read mode and last status tracking
    // ----------------------------------------
    logic       pend;
    logic       smode;
    logic       have_sr;
    logic [7:0] last_sr;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend  <= 1'b0;
            smode <= 1'b0;
        end else if (bus_we) begin
            pend  <= !pend && (bus_wdata[7:0] inside {8'h40, 8'h10, 8'h20});
            smode <= pend || (bus_wdata[7:0] inside {8'h70, 8'hB0, 8'hD0});
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            have_sr <= 1'b0;
            last_sr <= 8'h00;
        end else if (bus_we) begin
            have_sr <= 1'b0;
        end else if (bus_rvalid && smode) begin
            have_sr <= 1'b1;
            last_sr <= bus_rdata[7:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    rvalid_resp_a: assert property (bus_re |=> bus_rvalid)
        else $error("read strobe without answer");
    rvalid_cause_a: assert property (bus_rvalid |-> $past(bus_re))
        else $error("answer without read strobe");
    rdata_hold_a: assert property (!bus_rvalid |-> $stable(bus_rdata))
        else $error("read data moved without answer");
    status_shape_a: assert property (bus_rvalid && smode |->
        bus_rdata[15:8] == 8'h00 && !bus_rdata[0]) else $error("read not status");
    prog_pause_a: assert property (bus_rvalid && smode && bus_rdata[2] |-> bus_rdata[7])
        else $error("program pause without ready");
    abort_cause_a: assert property (bus_rvalid && smode && (bus_rdata[3] || bus_rdata[1])
        |-> bus_rdata[5] || bus_rdata[4]) else $error("abort without fail bit");
    sticky_err_a: assert property (bus_rvalid && smode && have_sr |->
        (bus_rdata[7:0] & last_sr & `FPSC_SR_ERR_MASK) == (last_sr & `FPSC_SR_ERR_MASK))
        else $error("error bit dropped without clear");
    pause_hold_a: assert property (bus_rvalid && smode && have_sr |->
        (bus_rdata[7:0] & last_sr & 8'h44) == (last_sr & 8'h44))
        else $error("pause bit dropped without resume");
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top import fpsc_pkg::*; ();
    logic        clock, rst_n, supply_low, op_valid, wp_level;
    logic        op_ready, done, done_error, op_busy, erase_held;
    logic [7:0]  block_locked;
    fpsc_op_e    op_code;
    logic [15:0] op_addr, op_data, done_data;
    int          n_mismatch, check_count;
    fpsc_if bus_if ();
    fpsc_device i_fpsc_device (.clock(clock), .rst_n(rst_n), .bus(bus_if),
        .supply_low(supply_low), .block_locked(block_locked), .op_busy(op_busy),
        .erase_held(erase_held));
    fpsc_host i_fpsc_host (.clock(clock), .rst_n(rst_n), .bus(bus_if), .op_valid(op_valid),
        .op_code(op_code), .op_addr(op_addr), .op_data(op_data), .wp_level(wp_level),
        .op_ready(op_ready), .done(done), .done_error(done_error), .done_data(done_data));
    fpsc_bus_assertions i_fpsc_bus_assertions (.clock(clock), .rst_n(rst_n),
        .bus_we(bus_if.bus_we), .bus_re(bus_if.bus_re), .bus_wdata(bus_if.bus_wdata),
        .bus_rdata(bus_if.bus_rdata), .bus_rvalid(bus_if.bus_rvalid));
    // ----------------------------------------
    // clock, checks and host operations
    // ----------------------------------------
    always #5 clock = ~clock;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task run(input fpsc_op_e c, input logic [15:0] a, d, input logic err, input logic [15:0] x);
        @(posedge clock);
        #1 op_valid = 1'b1;
        op_code = c;
        op_addr = a;
        op_data = d;
        @(posedge clock);
        #1 op_valid = 1'b0;
        if (c == OP_ERASE) begin
            repeat (err ? 2 : 10) @(posedge clock);
            #1 check({15'h0000, op_busy}, {15'h0000, !err});
        end
        wait_done(c, err, x);
    endtask
    task wait_done(input fpsc_op_e c, input logic err, input logic [15:0] x);
        int k;
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            @(posedge clock);
            #1 k++;
        end
        check({15'h0000, done}, 16'h0001);
        if (!(c inside {OP_READ_ARRAY, OP_CLEAR})) check(done_data, x);
        if (!(c inside {OP_READ_ARRAY, OP_CLEAR, OP_READ})) check({15'h0000, done_error}, {15'h0000, err});
    endtask
    task run_paused(input logic [15:0] a, input logic [15:0] x);
        @(posedge clock);
        #1 op_valid = 1'b1;
        op_code = OP_ERASE;
        op_addr = a;
        @(posedge clock);
        #1 op_code = OP_SUSPEND;
        repeat (4) @(posedge clock);
        #1 op_valid = 1'b0;
        wait_done(OP_SUSPEND, 1'b0, x);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end
    initial begin
        clock = 0; rst_n = 0; supply_low = 0; block_locked = 8'h00; op_valid = 0;
        op_code = OP_READ; op_addr = 16'h0000; op_data = 16'h0000; wp_level = 1;
        n_mismatch = 0; check_count = 0;
        repeat (8) @(posedge clock);
        #1 rst_n = 1;
        run(OP_READ_ARRAY, 16'h0000, 16'h0000, 0, 16'h0000);
        run(OP_READ, 16'h0005, 16'h0000, 0, 16'hFFFF);
        run(OP_PROGRAM, 16'h0005, 16'h1234, 0, 16'h0080);
        run(OP_READ_STATUS, 16'h0000, 16'h0000, 0, 16'h0080);
        run(OP_READ_ARRAY, 16'h0000, 16'h0000, 0, 16'h0000);
        run(OP_READ, 16'h0005, 16'h0000, 0, 16'h1234);
        supply_low = 1;
        repeat (20) @(posedge clock);
        #1 supply_low = 0;
        run(OP_READ_STATUS, 16'h0000, 16'h0000, 0, 16'h0080);
        supply_low = 1;
        run(OP_PROGRAM, 16'h0006, 16'h0000, 1, 16'h0098);
        supply_low = 0;
        run(OP_READ_STATUS, 16'h0000, 16'h0000, 0, 16'h0080);
        block_locked = 8'h02;
        wp_level = 0;
        run(OP_PROGRAM, 16'h0009, 16'h0F0F, 1, 16'h0092);
        wp_level = 1;
        run(OP_PROGRAM, 16'h0009, 16'h0F0F, 0, 16'h0080);
        supply_low = 1;
        run(OP_ERASE, 16'h0000, 16'h0000, 1, 16'h00A8);
        supply_low = 0;
        run(OP_ERASE, 16'h0000, 16'h0000, 0, 16'h0080);
        run(OP_READ_ARRAY, 16'h0000, 16'h0000, 0, 16'h0000);
        run(OP_READ, 16'h0005, 16'h0000, 0, 16'hFFFF);
        run(OP_READ, 16'h0009, 16'h0000, 0, 16'h0F0F);
        run_paused(16'h0010, 16'h00C0);
        check({15'h0000, erase_held}, 16'h0001);
        run(OP_PROGRAM, 16'h0005, 16'h00FF, 0, 16'h00C0);
        run(OP_READ_ARRAY, 16'h0000, 16'h0000, 0, 16'h0000);
        run(OP_READ, 16'h0005, 16'h0000, 0, 16'h00FF);
        run(OP_READ_STATUS, 16'h0000, 16'h0000, 0, 16'h00C0);
        run(OP_CLEAR, 16'h0000, 16'h0000, 0, 16'h0000);
        run(OP_READ, 16'h0005, 16'h0000, 0, 16'h00C0);
        run(OP_RESUME, 16'h0000, 16'h0000, 0, 16'h0080);
        check({15'h0000, erase_held}, 16'h0000);
        stop_test();
    end
endmodule
